// file: src/lcpmc_defines.svh
`ifndef LCPMC_DEFINES_SVH
`define LCPMC_DEFINES_SVH

// Register indices; byte address is four times the index.
`define LCPMC_IDX_CMD        5'h00
`define LCPMC_IDX_CH_FIRST   5'h01
`define LCPMC_IDX_CH_LAST    5'h12
`define LCPMC_IDX_BLINK_CFG  5'h13
`define LCPMC_IDX_LOAD       5'h14
`define LCPMC_IDX_STATUS     5'h15
`define LCPMC_ADDR_IDX_LSB   2
`define LCPMC_ADDR_IDX_MSB   6
`define LCPMC_ADDR_TOP_LSB   7

// Field positions and reset value.
`define LCPMC_REG_RESET      8'h00
`define LCPMC_CMD_SHDN_BIT   0
`define LCPMC_CMD_FORCE_LSB  1
`define LCPMC_CMD_FORCE_MSB  2
`define LCPMC_FORCE_AUTO     2'h0
`define LCPMC_FORCE_1X       2'h1
`define LCPMC_FORCE_15X      2'h2
`define LCPMC_FORCE_2X       2'h3
`define LCPMC_CH_LEVEL_MSB   5
`define LCPMC_CH_OD_LO_BIT   6
`define LCPMC_CH_OD_HI_BIT   7
`define LCPMC_CH_GPO_PULL_BIT 0
`define LCPMC_STAT_MODE_LSB  0
`define LCPMC_STAT_SHDN_BIT  2
`define LCPMC_STAT_SOFT_BIT  3
`define LCPMC_STAT_DROP_BIT  4
`define LCPMC_MODE_CODE_1X   2'h0
`define LCPMC_MODE_CODE_15X  2'h1
`define LCPMC_MODE_CODE_2X   2'h2

// Timing, from the 10 MHz system clock.
`define LCPMC_CLK_KHZ        10000
`define LCPMC_CLK_MHZ        10
`define LCPMC_PUMP_KHZ       850
`define LCPMC_PUMP_PERIOD    (`LCPMC_CLK_KHZ / `LCPMC_PUMP_KHZ)
`define LCPMC_PUMP_HALF      (`LCPMC_PUMP_PERIOD / 2)
`define LCPMC_DROP_US        400
`define LCPMC_DROP_CYCLES    (`LCPMC_DROP_US * `LCPMC_CLK_MHZ)
`define LCPMC_SOFT_US        125
`define LCPMC_SOFT_CYCLES    (`LCPMC_SOFT_US * `LCPMC_CLK_MHZ)

`endif

// file: src/lcpmc_phase_gen.sv
`timescale 1ns/10ps
`include "lcpmc_defines.svh"

module lcpmc_phase_gen (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic run,
  output logic      phaseOne,
  output logic      phaseTwo
);

  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic       next_phaseOne;
  logic       next_phaseTwo;

  // One dead cycle before each phase keeps the two phases from ever overlapping.
  always_comb begin
    next_cnt      = cnt;
    next_phaseOne = 1'b0;
    next_phaseTwo = 1'b0;
    if (!run) begin
      next_cnt = 4'h0;
    end else begin
      if (cnt == 4'(`LCPMC_PUMP_PERIOD - 1)) begin
        next_cnt = 4'h0;
      end else begin
        next_cnt = cnt + 4'h1;
      end
      next_phaseOne = (cnt >= 4'h1) && (cnt < 4'(`LCPMC_PUMP_HALF));
      next_phaseTwo = (cnt >= 4'(`LCPMC_PUMP_HALF + 1));
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt      <= 4'h0;
      phaseOne <= 1'b0;
      phaseTwo <= 1'b0;
    end else if (ce) begin
      cnt      <= next_cnt;
      phaseOne <= next_phaseOne;
      phaseTwo <= next_phaseTwo;
    end
  end

  chk_phase_overlap: assert property (@(posedge clock) disable iff (!nrst)
    !(phaseOne && phaseTwo)) else $error("pump phases overlap");

endmodule

// file: src/lcpmc_pkg.sv
package lcpmc_pkg;

  typedef enum logic [1:0] {
    LCPMC_MODE_1X,
    LCPMC_MODE_15X,
    LCPMC_MODE_2X
  } lcpmc_mode_e;

  // Switch drive for the pump power stage.
  typedef struct packed {
    logic weakPull;
    logic bypass;
    logic seriesCharge;
    logic parallelStack;
    logic cap1Charge;
    logic cap2Charge;
  } lcpmc_switch_s;

endpackage

// file: src/lcpmc_top.sv
// Behaviour
// - Reset and power-up leave the pump in 1x before any dropout change.
// - In 1x, a qualified dropout on an active output moves the pump to 1.5x.
// - In 1.5x, a further qualified dropout moves the pump to 2x.
// - Dropout must persist about 400 us; shorter dropouts change nothing.
// - Register writes, finished down ramps and blink period ends return to 1x.
// - The command register can force 1x, 1.5x or 2x.
// - Outputs with zero level never trigger mode changes.
// - Pump switches run from a two-phase non-overlapping clock near 850 kHz.
// - In 2x the flying capacitors charge on alternate phases.
// - In 1.5x capacitors charge in series in phase one, parallel in phase two.
// - In 1x the bypass switch closes and capacitor switching stops.
// - Each entry to 1.5x or 2x ramps the current limit over 125 us.
// - In shutdown only the weak input-to-output switch is enabled.
// - The low reset input clears all registers and forces shutdown.
// - Logic supply undervoltage resets all data registers.
// - A channel whose level register is zero is disabled.
// - Each of eighteen outputs gets a 6-bit linear level code.
// - Any output may instead act as an open-drain general output.
// - Data is taken one unit per transfer cycle, exactly once.
// - Bits 6 and 7 both high select open-drain mode.
// - Open-drain outputs never contribute dropout.
// - A load pulse copies all held channel registers to the active ones at once.
// - Writing the shutdown bit to one enters shutdown.
`timescale 1ns/10ps
`include "lcpmc_defines.svh"

module lcpmc_top (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic [31:0]                 hrdata,
  output logic                        hresp,
  input  wire logic [17:0]            dropoutRaw,
  input  wire logic                   logicSupplyLow,
  input  wire logic                   gradDownDone,
  input  wire logic                   blinkPeriodEnd,
  output lcpmc_pkg::lcpmc_switch_s    pumpSwitches,
  output logic [10:0]                 pumpCurrentLimit,
  output lcpmc_pkg::lcpmc_mode_e      pumpMode,
  output logic                        shutdownOut,
  output logic [17:0][5:0]            ledLevel,
  output logic [17:0]                 ledEnable,
  output logic [17:0]                 openDrainOe,
  output logic [7:0]                  blinkGradConfig
);

  logic [17:0]                dropMeta;
  logic [17:0]                dropSync;
  logic                       uvloMeta;
  logic                       uvlo;
  logic                       wrPend;
  logic                       next_wrPend;
  logic [4:0]                 wrIdx;
  logic [4:0]                 next_wrIdx;
  logic                       wrMapped;
  logic                       next_wrMapped;
  logic [31:0]                next_hrdata;
  logic [7:0]                 cmdReg;
  logic [7:0]                 next_cmdReg;
  logic [7:0]                 cfgReg;
  logic [7:0]                 next_cfgReg;
  logic [7:0]                 heldCh [18];
  logic [7:0]                 next_heldCh [18];
  logic [7:0]                 activeCh [18];
  logic [7:0]                 next_activeCh [18];
  logic                       loadPulse;
  logic                       busWrite;
  logic [17:0]                odMode;
  logic [17:0]                levelNonZero;
  logic [17:0]                dropMask;
  logic                       dropAny;
  logic                       dropQual;
  logic                       shutdown;
  logic [1:0]                 forceSel;
  lcpmc_pkg::lcpmc_mode_e     next_mode;
  logic [11:0]                dropCnt;
  logic [11:0]                next_dropCnt;
  logic [10:0]                next_softCnt;
  logic                       softActive;
  logic                       phaseOne;
  logic                       phaseTwo;
  lcpmc_pkg::lcpmc_switch_s   next_pumpSwitches;
  logic [17:0]                next_ledEnable;
  logic [17:0]                next_openDrainOe;

  // Pins from outside the clock domain pass two flops before any logic reads them.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dropMeta <= 18'h00000;
      dropSync <= 18'h00000;
      uvloMeta <= 1'b0;
      uvlo     <= 1'b0;
    end else if (ce) begin
      dropMeta <= dropoutRaw;
      dropSync <= dropMeta;
      uvloMeta <= logicSupplyLow;
      uvlo     <= uvloMeta;
    end
  end

  // Zero wait states and always OKAY, so the slave never stalls the master.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign busWrite  = wrPend && wrMapped && (wrIdx != `LCPMC_IDX_STATUS);
  assign loadPulse = wrPend && wrMapped && (wrIdx == `LCPMC_IDX_LOAD);

  // Address phase is captured once per accepted transfer; reads are answered in the data phase.
  always_comb begin
    logic [4:0] idx;
    idx           = haddr[`LCPMC_ADDR_IDX_MSB:`LCPMC_ADDR_IDX_LSB];
    next_wrPend   = 1'b0;
    next_wrIdx    = wrIdx;
    next_wrMapped = wrMapped;
    next_hrdata   = hrdata;
    if (hsel && hready && htrans[1]) begin
      next_wrPend   = hwrite;
      next_wrIdx    = idx;
      next_wrMapped = (haddr[31:`LCPMC_ADDR_TOP_LSB] == 25'h0000000)
                      && (idx <= `LCPMC_IDX_STATUS);
      next_hrdata   = 32'h00000000;
      if (!hwrite && next_wrMapped) begin
        if (idx == `LCPMC_IDX_CMD) begin
          next_hrdata[7:0] = cmdReg;
        end else if (idx == `LCPMC_IDX_BLINK_CFG) begin
          next_hrdata[7:0] = cfgReg;
        end else if (idx == `LCPMC_IDX_STATUS) begin
          next_hrdata[`LCPMC_STAT_MODE_LSB +: 2] =
            (pumpMode == lcpmc_pkg::LCPMC_MODE_1X)  ? `LCPMC_MODE_CODE_1X :
            (pumpMode == lcpmc_pkg::LCPMC_MODE_15X) ? `LCPMC_MODE_CODE_15X :
                                                      `LCPMC_MODE_CODE_2X;
          next_hrdata[`LCPMC_STAT_SHDN_BIT] = shutdown;
          next_hrdata[`LCPMC_STAT_SOFT_BIT] = softActive;
          next_hrdata[`LCPMC_STAT_DROP_BIT] = dropAny;
        end else if (idx != `LCPMC_IDX_LOAD) begin
          next_hrdata[7:0] = heldCh[idx - `LCPMC_IDX_CH_FIRST];
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wrPend   <= 1'b0;
      wrIdx    <= 5'h00;
      wrMapped <= 1'b0;
      hrdata   <= 32'h00000000;
    end else if (ce) begin
      wrPend   <= next_wrPend;
      wrIdx    <= next_wrIdx;
      wrMapped <= next_wrMapped;
      hrdata   <= next_hrdata;
    end
  end

  // Held registers take bus data; the load pulse moves them all to the active set together.
  always_comb begin
    next_cmdReg = cmdReg;
    next_cfgReg = cfgReg;
    for (int i = 0; i < 18; i++) begin
      next_heldCh[i]   = heldCh[i];
      next_activeCh[i] = loadPulse ? heldCh[i] : activeCh[i];
    end
    if (busWrite) begin
      if (wrIdx == `LCPMC_IDX_CMD) begin
        next_cmdReg = hwdata[7:0];
      end else if (wrIdx == `LCPMC_IDX_BLINK_CFG) begin
        next_cfgReg = hwdata[7:0];
      end else if (wrIdx != `LCPMC_IDX_LOAD) begin
        next_heldCh[wrIdx - `LCPMC_IDX_CH_FIRST] = hwdata[7:0];
      end
    end
    // Undervoltage clears every data register, and wins over a write in the same cycle.
    if (uvlo) begin
      next_cmdReg = `LCPMC_REG_RESET;
      next_cfgReg = `LCPMC_REG_RESET;
      for (int i = 0; i < 18; i++) begin
        next_heldCh[i]   = `LCPMC_REG_RESET;
        next_activeCh[i] = `LCPMC_REG_RESET;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmdReg <= `LCPMC_REG_RESET;
      cfgReg <= `LCPMC_REG_RESET;
      for (int i = 0; i < 18; i++) begin
        heldCh[i]   <= `LCPMC_REG_RESET;
        activeCh[i] <= `LCPMC_REG_RESET;
      end
    end else if (ce) begin
      cmdReg <= next_cmdReg;
      cfgReg <= next_cfgReg;
      for (int i = 0; i < 18; i++) begin
        heldCh[i]   <= next_heldCh[i];
        activeCh[i] <= next_activeCh[i];
      end
    end
  end

  // Channel decode: zero level disables a channel, bits 6 and 7 pick open-drain use.
  always_comb begin
    for (int i = 0; i < 18; i++) begin
      odMode[i]       = activeCh[i][`LCPMC_CH_OD_LO_BIT] && activeCh[i][`LCPMC_CH_OD_HI_BIT];
      levelNonZero[i] = (activeCh[i][`LCPMC_CH_LEVEL_MSB:0] != 6'h00);
    end
  end

  // Unprogrammed and open-drain channels are masked out of dropout.
  assign dropMask = dropSync & levelNonZero & ~odMode;
  assign dropAny  = |dropMask;
  assign dropQual = dropAny && (dropCnt == 12'(`LCPMC_DROP_CYCLES - 1));
  assign shutdown = cmdReg[`LCPMC_CMD_SHDN_BIT] || uvlo || (levelNonZero == 18'h00000);
  assign forceSel = cmdReg[`LCPMC_CMD_FORCE_MSB:`LCPMC_CMD_FORCE_LSB];
  assign softActive = (pumpMode != lcpmc_pkg::LCPMC_MODE_1X)
                      && (pumpCurrentLimit < 11'(`LCPMC_SOFT_CYCLES));

  // Mode sequencing. Priority: shutdown, forced mode, return to 1x, then dropout steps.
  always_comb begin
    next_mode    = pumpMode;
    next_dropCnt = 12'h000;
    next_softCnt = pumpCurrentLimit;
    if (shutdown) begin
      next_mode = lcpmc_pkg::LCPMC_MODE_1X;
    end else if (forceSel != `LCPMC_FORCE_AUTO) begin
      // A forced mode ignores dropout and every automatic return.
      unique case (forceSel)
        `LCPMC_FORCE_1X:  next_mode = lcpmc_pkg::LCPMC_MODE_1X;
        `LCPMC_FORCE_15X: next_mode = lcpmc_pkg::LCPMC_MODE_15X;
        default:          next_mode = lcpmc_pkg::LCPMC_MODE_2X;
      endcase
    end else if (busWrite || gradDownDone || blinkPeriodEnd) begin
      next_mode = lcpmc_pkg::LCPMC_MODE_1X;
    end else if (dropQual) begin
      unique case (pumpMode)
        lcpmc_pkg::LCPMC_MODE_1X:  next_mode = lcpmc_pkg::LCPMC_MODE_15X;
        lcpmc_pkg::LCPMC_MODE_15X: next_mode = lcpmc_pkg::LCPMC_MODE_2X;
        lcpmc_pkg::LCPMC_MODE_2X:  next_mode = lcpmc_pkg::LCPMC_MODE_2X;
      endcase
    end else if (dropAny && (pumpMode != lcpmc_pkg::LCPMC_MODE_2X)) begin
      next_dropCnt = dropCnt + 12'h001;
    end
    // Restart the limit ramp on every step into a boost mode.
    if ((next_mode != pumpMode) && (next_mode != lcpmc_pkg::LCPMC_MODE_1X)) begin
      next_softCnt = 11'h000;
    end else if (pumpCurrentLimit < 11'(`LCPMC_SOFT_CYCLES)) begin
      next_softCnt = pumpCurrentLimit + 11'h001;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pumpMode         <= lcpmc_pkg::LCPMC_MODE_1X;
      dropCnt          <= 12'h000;
      pumpCurrentLimit <= 11'h000;
    end else if (ce) begin
      pumpMode         <= next_mode;
      dropCnt          <= next_dropCnt;
      pumpCurrentLimit <= next_softCnt;
    end
  end

  // The phase clock only runs in boost modes; in 1x the switch decode drives only bypass and ignores the phases.
  lcpmc_phase_gen u_phase (
    .clock    (clock),
    .nrst     (nrst),
    .ce       (ce),
    .run      (!shutdown && (pumpMode != lcpmc_pkg::LCPMC_MODE_1X)),
    .phaseOne (phaseOne),
    .phaseTwo (phaseTwo)
  );

  // Power switch and channel drive, registered so the pins never glitch.
  always_comb begin
    next_pumpSwitches = '0;
    if (shutdown) begin
      next_pumpSwitches.weakPull = 1'b1;
    end else begin
      unique case (pumpMode)
        lcpmc_pkg::LCPMC_MODE_1X: begin
          next_pumpSwitches.bypass = 1'b1;
        end
        lcpmc_pkg::LCPMC_MODE_15X: begin
          next_pumpSwitches.seriesCharge  = phaseOne;
          next_pumpSwitches.parallelStack = phaseTwo;
        end
        lcpmc_pkg::LCPMC_MODE_2X: begin
          next_pumpSwitches.cap1Charge = phaseOne;
          next_pumpSwitches.cap2Charge = phaseTwo;
        end
      endcase
    end
    for (int i = 0; i < 18; i++) begin
      next_ledEnable[i]   = !shutdown && levelNonZero[i] && !odMode[i];
      next_openDrainOe[i] = odMode[i] && activeCh[i][`LCPMC_CH_GPO_PULL_BIT];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pumpSwitches <= '0;
      ledEnable    <= 18'h00000;
      openDrainOe  <= 18'h00000;
      shutdownOut  <= 1'b1;
    end else if (ce) begin
      pumpSwitches <= next_pumpSwitches;
      ledEnable    <= next_ledEnable;
      openDrainOe  <= next_openDrainOe;
      shutdownOut  <= shutdown;
    end
  end

  // Active levels straight from the active flops.
  always_comb begin
    for (int i = 0; i < 18; i++) begin
      ledLevel[i] = activeCh[i][`LCPMC_CH_LEVEL_MSB:0];
    end
  end
  assign blinkGradConfig = cfgReg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  chk_shutdown_mode_1x: assert property (ce && shutdown |=> pumpMode == lcpmc_pkg::LCPMC_MODE_1X)
    else $error("mode not 1x in shutdown");
  chk_step_to_15x: assert property (ce && !shutdown && forceSel == `LCPMC_FORCE_AUTO
    && !busWrite && !gradDownDone && !blinkPeriodEnd && dropQual
    && pumpMode == lcpmc_pkg::LCPMC_MODE_1X |=> pumpMode == lcpmc_pkg::LCPMC_MODE_15X)
    else $error("no step to 1.5x");
  chk_step_to_2x: assert property (ce && !shutdown && forceSel == `LCPMC_FORCE_AUTO
    && !busWrite && !gradDownDone && !blinkPeriodEnd && dropQual
    && pumpMode == lcpmc_pkg::LCPMC_MODE_15X |=> pumpMode == lcpmc_pkg::LCPMC_MODE_2X)
    else $error("no step to 2x");
  chk_short_drop: assert property (ce && forceSel == `LCPMC_FORCE_AUTO && !dropQual
    && pumpMode == lcpmc_pkg::LCPMC_MODE_1X |=> pumpMode == lcpmc_pkg::LCPMC_MODE_1X)
    else $error("mode rose without qualified dropout");
  chk_return_1x: assert property (ce && forceSel == `LCPMC_FORCE_AUTO
    && (busWrite || gradDownDone || blinkPeriodEnd) |=> pumpMode == lcpmc_pkg::LCPMC_MODE_1X)
    else $error("no return to 1x");
  chk_forced_2x: assert property (ce && !shutdown && forceSel == `LCPMC_FORCE_2X
    |=> pumpMode == lcpmc_pkg::LCPMC_MODE_2X) else $error("forced 2x not held");
  chk_zero_masked: assert property (ce && ((dropSync & levelNonZero) == 18'h00000)
    |=> dropCnt == 12'h000) else $error("zero level channel seen as dropout");
  chk_bypass_1x: assert property (ce && !shutdown && pumpMode == lcpmc_pkg::LCPMC_MODE_1X
    |=> pumpSwitches.bypass && !pumpSwitches.cap1Charge && !pumpSwitches.seriesCharge)
    else $error("1x switches wrong");
  chk_soft_restart: assert property (ce && pumpMode == lcpmc_pkg::LCPMC_MODE_1X ##1
    pumpMode == lcpmc_pkg::LCPMC_MODE_15X |-> pumpCurrentLimit == 11'h000)
    else $error("soft start not restarted");
  chk_weak_only: assert property (ce && shutdown |=> pumpSwitches.weakPull
    && !pumpSwitches.bypass) else $error("shutdown switches wrong");
  chk_load_copy: assert property (ce && loadPulse && !uvlo |=> activeCh[0] == $past(heldCh[0])
    && activeCh[17] == $past(heldCh[17])) else $error("load did not copy");

  cov_reach_2x: cover property (pumpMode == lcpmc_pkg::LCPMC_MODE_2X
    && forceSel == `LCPMC_FORCE_AUTO);
  cov_forced_15x: cover property (forceSel == `LCPMC_FORCE_15X
    && pumpMode == lcpmc_pkg::LCPMC_MODE_15X);
  cov_load: cover property (loadPulse);
  cov_od_channel: cover property (|openDrainOe);

endmodule

// file: test/lcpmc_host_model.sv
`timescale 1ns/10ps

// Register host on the far side; it issues single whole-word AHB-Lite transfers.
module lcpmc_host_model (
  input  wire logic        clock,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  // The bus idles with no transfer requested.
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One register word per transfer, address phase then data phase.
  task automatic xfer(input logic [4:0] idx, input logic wr, input logic [7:0] wd,
                      output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {25'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, wd};
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    rd = hrdata;
    // Released lines change so that no stale value looks valid.
    haddr <= ~haddr;
    hwdata <= ~hwdata;
  endtask
endmodule

// file: test/lcpmc_top_tb.sv
`timescale 1ns/10ps

module lcpmc_top_tb;
  logic                          clock;
  logic                          nrst;
  logic                          ce;
  logic                          hsel;
  logic [31:0]                   haddr;
  logic [1:0]                    htrans;
  logic                          hwrite;
  logic [2:0]                    hsize;
  logic [31:0]                   hwdata;
  logic                          hreadyout;
  logic [31:0]                   hrdata;
  logic                          hresp;
  logic [17:0]                   dropoutRaw;
  logic                          logicSupplyLow;
  logic                          gradDownDone;
  logic                          blinkPeriodEnd;
  lcpmc_pkg::lcpmc_switch_s      pumpSwitches;
  logic [10:0]                   pumpCurrentLimit;
  lcpmc_pkg::lcpmc_mode_e        pumpMode;
  logic                          shutdownOut;
  logic [17:0][5:0]              ledLevel;
  logic [17:0]                   ledEnable;
  logic [17:0]                   openDrainOe;
  logic [7:0]                    blinkGradConfig;
  logic [31:0]                   rd;
  int                            failures;
  int                            compares;
  int                            cycles;

  lcpmc_top DUT (.clock(clock), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .dropoutRaw(dropoutRaw),
    .logicSupplyLow(logicSupplyLow), .gradDownDone(gradDownDone),
    .blinkPeriodEnd(blinkPeriodEnd), .pumpSwitches(pumpSwitches),
    .pumpCurrentLimit(pumpCurrentLimit), .pumpMode(pumpMode), .shutdownOut(shutdownOut),
    .ledLevel(ledLevel), .ledEnable(ledEnable), .openDrainOe(openDrainOe),
    .blinkGradConfig(blinkGradConfig));

  lcpmc_host_model host (.clock(clock), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // The clock toggles every half period of 50 ns.
  initial clock = 1'b0;
  always #50 clock = ~clock;

  task automatic final_report;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // The run should need about 23000 cycles, so a hang is cut off well beyond that.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 45000) begin
      failures++;
      $display("BAD %0t timeout", $time);
      final_report;
    end
  end

  task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Checks run at the falling edge, where registered outputs have settled.
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    host.xfer(idx, 1'b1, d, rd);
    cyc(4);
  endtask

  task automatic rdReg(input logic [4:0] idx);
    host.xfer(idx, 1'b0, 8'h00, rd);
    @(negedge clock);
  endtask

  // Waits a bounded time for a mode; a late or missing step shows as a mismatch.
  task automatic waitMode(input lcpmc_pkg::lcpmc_mode_e m, input int lim);
    int n;
    n = 0;
    while (pumpMode !== m && n < lim) begin
      @(negedge clock);
      n++;
    end
    checkVal({30'h0, pumpMode}, {30'h0, m});
  endtask

  // Over two pump periods both phases must appear and never overlap.
  task automatic phases(input logic twoX);
    logic a;
    logic b;
    logic both;
    a = 1'b0;
    b = 1'b0;
    both = 1'b0;
    repeat (22) begin
      @(negedge clock);
      a |= twoX ? pumpSwitches.cap1Charge : pumpSwitches.seriesCharge;
      b |= twoX ? pumpSwitches.cap2Charge : pumpSwitches.parallelStack;
      both |= twoX ? pumpSwitches.cap1Charge & pumpSwitches.cap2Charge
                   : pumpSwitches.seriesCharge & pumpSwitches.parallelStack;
    end
    checkVal({29'h0, a, b, both}, 32'h6);
    checkVal({31'h0, pumpSwitches.bypass}, 32'h0);
  endtask

  task automatic pulse(input logic which);
    @(posedge clock);
    if (which) gradDownDone <= 1'b1;
    else blinkPeriodEnd <= 1'b1;
    @(posedge clock);
    gradDownDone <= 1'b0;
    blinkPeriodEnd <= 1'b0;
  endtask

  task automatic drop(input logic [17:0] m, input int n);
    @(posedge clock);
    dropoutRaw <= m;
    repeat (n) @(posedge clock);
    dropoutRaw <= 18'h0;
    cyc(4);
  endtask

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    dropoutRaw = 18'h0;
    logicSupplyLow = 1'b0;
    gradDownDone = 1'b0;
    blinkPeriodEnd = 1'b0;
    failures = 0;
    compares = 0;
    cycles = 0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    cyc(2);
    checkVal({30'h0, pumpMode}, {30'h0, lcpmc_pkg::LCPMC_MODE_1X});
    checkVal({31'h0, shutdownOut}, 32'h1);
    checkVal({26'h0, pumpSwitches}, 32'h20);
    // Channel one lit, channel two off, channel three open drain pulling low.
    wr(5'h01, 8'h20);
    wr(5'h03, 8'hC1);
    wr(5'h14, 8'h00);
    rdReg(5'h01);
    checkVal(rd, 32'h20);
    checkVal({26'h0, ledLevel[0]}, 32'h20);
    checkVal({29'h0, ledEnable[1:0], shutdownOut}, 32'h2);
    checkVal({31'h0, openDrainOe[2]}, 32'h1);
    checkVal({31'h0, pumpSwitches.bypass}, 32'h1);
    rdReg(5'h19);
    checkVal(rd, 32'h0);
    // The config register reads back and drives its output; the bus always answers OKAY.
    wr(5'h13, 8'h5A);
    rdReg(5'h13);
    checkVal(rd, 32'h5A);
    checkVal({23'h0, hresp, blinkGradConfig}, 32'h5A);
    drop(18'h1, 1000);
    checkVal({30'h0, pumpMode}, {30'h0, lcpmc_pkg::LCPMC_MODE_1X});
    // Unprogrammed and open-drain channels hold dropout past the qualifying time.
    drop(18'h6, 4100);
    checkVal({30'h0, pumpMode}, {30'h0, lcpmc_pkg::LCPMC_MODE_1X});
    @(posedge clock);
    dropoutRaw <= 18'h1;
    cyc(3990);
    checkVal({30'h0, pumpMode}, {30'h0, lcpmc_pkg::LCPMC_MODE_1X});
    waitMode(lcpmc_pkg::LCPMC_MODE_15X, 40);
    // A low clock enable must freeze the ramp mid-way.
    @(posedge clock);
    ce <= 1'b0;
    cyc(2);
    rd = {21'h0, pumpCurrentLimit};
    cyc(20);
    checkVal({21'h0, pumpCurrentLimit}, rd);
    @(posedge clock);
    ce <= 1'b1;
    rdReg(5'h15);
    checkVal(rd, 32'h19);
    cyc(1300);
    checkVal({21'h0, pumpCurrentLimit}, 32'd1250);
    phases(1'b0);
    pulse(1'b1);
    waitMode(lcpmc_pkg::LCPMC_MODE_1X, 6);
    waitMode(lcpmc_pkg::LCPMC_MODE_15X, 4100);
    waitMode(lcpmc_pkg::LCPMC_MODE_2X, 4100);
    phases(1'b1);
    pulse(1'b0);
    waitMode(lcpmc_pkg::LCPMC_MODE_1X, 6);
    // Forced 1x holds against dropout; then each forced code in turn.
    wr(5'h00, 8'h02);
    cyc(4100);
    checkVal({30'h0, pumpMode}, {30'h0, lcpmc_pkg::LCPMC_MODE_1X});
    wr(5'h00, 8'h06);
    waitMode(lcpmc_pkg::LCPMC_MODE_2X, 6);
    pulse(1'b0);
    cyc(4);
    checkVal({30'h0, pumpMode}, {30'h0, lcpmc_pkg::LCPMC_MODE_2X});
    wr(5'h00, 8'h04);
    waitMode(lcpmc_pkg::LCPMC_MODE_15X, 6);
    @(posedge clock);
    dropoutRaw <= 18'h0;
    wr(5'h00, 8'h01);
    checkVal({31'h0, shutdownOut}, 32'h1);
    checkVal({26'h0, pumpSwitches}, 32'h20);
    wr(5'h00, 8'h00);
    @(posedge clock);
    logicSupplyLow <= 1'b1;
    cyc(6);
    @(posedge clock);
    logicSupplyLow <= 1'b0;
    rdReg(5'h01);
    checkVal(rd, 32'h0);
    checkVal({26'h0, ledLevel[0]}, 32'h0);
    checkVal({24'h0, blinkGradConfig}, 32'h0);
    final_report;
  end
endmodule
